//--- rsb_slip_buffer.sv
package rsb_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets, one per aligned word
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;   // slip_buffer_event_status, clear on read
    localparam logic [ADDR_W-1:0] REG_ENABLE = 8'h04;   // interrupt enable
    localparam logic [ADDR_W-1:0] REG_CLEAR  = 8'h08;   // write-only clear
    localparam logic [ADDR_W-1:0] REG_LEVEL  = 8'h0c;   // buffer fill level

    // status field layout
    localparam int FLAG_W       = 3;
    localparam int BIT_SLIP     = 0;
    localparam int BIT_UNDERRUN = 1;
    localparam int BIT_OVERFLOW = 2;
    localparam logic [FLAG_W-1:0] STATUS_RST = 3'h0;
    localparam logic [FLAG_W-1:0] ENABLE_RST = 3'h0;

    // slip buffer geometry: two e1 frames of 32 timeslots
    localparam int FRAME_BYTES = 32;
    localparam int BUF_DEPTH   = 64;
    localparam int PTR_W       = 6;
    localparam int CNT_W       = 7;
    localparam logic [PTR_W-1:0] FRAME_PTR = 6'h20;
    localparam logic [CNT_W-1:0] FRAME_CNT = 7'h20;
    localparam logic [CNT_W-1:0] FULL_CNT  = 7'h40;
endpackage : rsb_pkg

`timescale 1ns/100ps

module rsb_slip_buffer
    import rsb_pkg::*;
(
    input  wire logic              clock,       // framer clock
    input  wire logic              arst_n,      // async reset, active low
    input  wire logic [7:0]        wrData,      // byte from the line side
    input  wire logic              wrEn,        // write one byte
    input  wire logic              rdEn,        // read one byte
    output logic      [7:0]        rdData,      // byte to the system side
    output logic                   rdValid,     // rdData is new this cycle
    output logic                   underrunEvt, // read hit an empty buffer
    output logic                   overflowEvt, // write hit a full buffer
    output logic      [CNT_W-1:0]  fillLevel    // bytes held
);
    logic [7:0]       mem [BUF_DEPTH];
    logic [PTR_W-1:0] wrPtr_ff, nxt_wrPtr;
    logic [PTR_W-1:0] rdPtr_ff, nxt_rdPtr;
    logic [CNT_W-1:0] count_ff, nxt_count;
    logic [7:0]       rdData_ff, nxt_rdData;
    logic             rdValid_ff, nxt_rdValid;
    logic             under_ff, nxt_under;
    logic             over_ff, nxt_over;
    logic             readEmpty;
    logic             writeFull;
    logic [PTR_W-1:0] readAddr;

    // slip decisions; a replay steps back one frame, a discard drops the oldest frame
    always_comb begin
        readEmpty   = rdEn && (count_ff == '0);
        writeFull   = wrEn && (count_ff == FULL_CNT);
        readAddr    = readEmpty ? rdPtr_ff - FRAME_PTR : rdPtr_ff;
        nxt_wrPtr   = wrPtr_ff + PTR_W'(wrEn);
        nxt_rdPtr   = readAddr + PTR_W'(rdEn) + (writeFull ? FRAME_PTR : '0);
        nxt_count   = count_ff + (readEmpty ? FRAME_CNT : '0) - CNT_W'(rdEn)
                      + CNT_W'(wrEn) - (writeFull ? FRAME_CNT : '0);
        nxt_rdData  = rdEn ? mem[readAddr] : rdData_ff;
        nxt_rdValid = rdEn;
        nxt_under   = readEmpty;
        nxt_over    = writeFull;
    end

    // storage has no reset; contents before the first frame are don't-care
    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrPtr_ff] <= wrData;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_ff   <= '0;
            rdPtr_ff   <= '0;
            count_ff   <= '0;
            rdData_ff  <= 8'h00;
            rdValid_ff <= 1'b0;
            under_ff   <= 1'b0;
            over_ff    <= 1'b0;
        end else begin
            wrPtr_ff   <= nxt_wrPtr;
            rdPtr_ff   <= nxt_rdPtr;
            count_ff   <= nxt_count;
            rdData_ff  <= nxt_rdData;
            rdValid_ff <= nxt_rdValid;
            under_ff   <= nxt_under;
            over_ff    <= nxt_over;
        end
    end

    assign rdData      = rdData_ff;
    assign rdValid     = rdValid_ff;
    assign underrunEvt = under_ff;
    assign overflowEvt = over_ff;
    assign fillLevel   = count_ff;
endmodule : rsb_slip_buffer

//--- rsb_status_flags.sv
// How it works
// R1: bit 1 flags underrun since last read
// R2: empty read replays a frame, sets underrun
// R3: bit 0 flags any slip, read clears
// R4: full write drops a frame, sets slip
// R5: software checks bits 1/2 for slip cause
// R6: bit 2 flags overflow, read clears
// R7: event during status read is kept
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps

module rsb_status_flags
    import rsb_pkg::*;
(
    input  wire logic              clock,     // framer clock, 25 MHz
    input  wire logic              arst_n,    // async reset, active low
    input  wire logic [ADDR_W-1:0] regAddr,   // register byte address
    input  wire logic [DATA_W-1:0] regWrData, // register write data
    input  wire logic              regWr,     // write strobe
    input  wire logic              regRd,     // read strobe
    output logic      [DATA_W-1:0] regRdData, // read data, cycle after regRd
    input  wire logic [7:0]        lineData,  // received byte
    input  wire logic              lineWr,    // received byte strobe
    input  wire logic              sysRd,     // system read request
    output logic      [7:0]        sysData,   // byte to system
    output logic                   sysValid,  // sysData fresh
    output logic                   irq        // level interrupt
);
    logic [FLAG_W-1:0] statusFlags_ff, nxt_statusFlags;
    logic [FLAG_W-1:0] intEnable_ff, nxt_intEnable;
    logic [DATA_W-1:0] rdData_ff, nxt_rdData;
    logic              irq_ff, nxt_irq;
    logic [FLAG_W-1:0] setMask;
    logic [FLAG_W-1:0] clrMask;
    logic              underrunEvt;
    logic              overflowEvt;
    logic [CNT_W-1:0]  fillLevel;

    // a flag that hardware sets while software clears stays set
    function automatic logic [FLAG_W-1:0] setWins(input logic [FLAG_W-1:0] cur,
                                                 input logic [FLAG_W-1:0] set,
                                                 input logic [FLAG_W-1:0] clr);
        setWins = (cur & ~clr) | set;
    endfunction : setWins

    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] target);
        hit = strobe && (addr == target);
    endfunction : hit

    rsb_slip_buffer u_buffer (
        .clock       (clock),
        .arst_n      (arst_n),
        .wrData      (lineData),
        .wrEn        (lineWr),
        .rdEn        (sysRd),
        .rdData      (sysData),
        .rdValid     (sysValid),
        .underrunEvt (underrunEvt),
        .overflowEvt (overflowEvt),
        .fillLevel   (fillLevel)
    );

    // events into flags; the read clears what it returned, not what arrives with it
    always_comb begin
        setMask                = '0;
        setMask[BIT_UNDERRUN]  = underrunEvt;                  // R1 R2
        setMask[BIT_OVERFLOW]  = overflowEvt;                  // R6
        setMask[BIT_SLIP]      = underrunEvt | overflowEvt;    // R3 R4
        clrMask                = '0;
        if (hit(regRd, regAddr, REG_STATUS)) begin
            clrMask = '1;                                      // R1 R3 R6
        end
        if (hit(regWr, regAddr, REG_CLEAR)) begin
            clrMask = clrMask | regWrData[FLAG_W-1:0];
        end
        nxt_statusFlags = setWins(statusFlags_ff, setMask, clrMask); // R7
        nxt_intEnable   = intEnable_ff;
        if (hit(regWr, regAddr, REG_ENABLE)) begin
            nxt_intEnable = regWrData[FLAG_W-1:0];
        end
        nxt_irq = |(nxt_statusFlags & nxt_intEnable);
    end

    // read mux; unmapped and write-only addresses read as zero
    always_comb begin
        nxt_rdData = '0;
        if (regRd) begin
            unique case (regAddr)
                REG_STATUS: nxt_rdData = DATA_W'(statusFlags_ff);   // R7
                REG_ENABLE: nxt_rdData = DATA_W'(intEnable_ff);
                REG_LEVEL:  nxt_rdData = DATA_W'(fillLevel);
                default:    nxt_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            statusFlags_ff <= STATUS_RST;
            intEnable_ff   <= ENABLE_RST;
            rdData_ff      <= '0;
            irq_ff         <= 1'b0;
        end else begin
            statusFlags_ff <= nxt_statusFlags;
            intEnable_ff   <= nxt_intEnable;
            rdData_ff      <= nxt_rdData;
            irq_ff         <= nxt_irq;
        end
    end

    assign regRdData = rdData_ff;
    assign irq       = irq_ff;

    // checks
    sequence statusRead_s;
        regRd && regAddr == REG_STATUS;
    endsequence

    sequence emptyRead_s;
        sysRd && fillLevel == '0 && !lineWr;
    endsequence

    sequence fullWrite_s;
        lineWr && fillLevel == FULL_CNT && !sysRd;
    endsequence

    underrun_flag_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
        underrunEvt |=> statusFlags_ff[BIT_UNDERRUN])
        else $error("underrun event did not set its flag");

    replay_frame_a: assert property (@(posedge clock) disable iff (!arst_n) // R2
        emptyRead_s |=> underrunEvt && fillLevel == FRAME_CNT - 7'h01 ##1 statusFlags_ff[BIT_UNDERRUN])
        else $error("empty read did not replay a frame");

    slip_flag_a: assert property (@(posedge clock) disable iff (!arst_n) // R3
        (underrunEvt || overflowEvt) |=> statusFlags_ff[BIT_SLIP])
        else $error("slip event did not set slip flag");

    drop_frame_a: assert property (@(posedge clock) disable iff (!arst_n) // R4
        fullWrite_s |=> overflowEvt && fillLevel == FULL_CNT - FRAME_CNT + 7'h01
                        ##1 statusFlags_ff[BIT_SLIP])
        else $error("full write did not drop a frame");

    overflow_flag_a: assert property (@(posedge clock) disable iff (!arst_n) // R6
        overflowEvt |=> statusFlags_ff[BIT_OVERFLOW] && statusFlags_ff[BIT_SLIP])
        else $error("overflow event did not set its flags");

    read_clears_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
        statusRead_s ##0 (!underrunEvt && !overflowEvt && !regWr) |=> statusFlags_ff == '0)
        else $error("status read did not clear flags");

    read_returns_a: assert property (@(posedge clock) disable iff (!arst_n) // R7
        statusRead_s |=> regRdData == DATA_W'($past(statusFlags_ff)))
        else $error("status read returned wrong value");

    event_kept_a: assert property (@(posedge clock) disable iff (!arst_n) // R7
        statusRead_s ##0 underrunEvt |=> statusFlags_ff[BIT_UNDERRUN] && statusFlags_ff[BIT_SLIP])
        else $error("event lost during status read");

    // irq is registered from the same next values as flags and enable, so it lines up with them
    irq_level_a: assert property (@(posedge clock) disable iff (!arst_n)
        irq == |(statusFlags_ff & intEnable_ff))
        else $error("interrupt does not follow enabled flags");

    // register side sequences, kept as plain boolean steps
    sequence enableWrite_s;
        regWr && regAddr == REG_ENABLE;
    endsequence

    sequence clearWrite_s;
        regWr && regAddr == REG_CLEAR;
    endsequence

    sequence enableRead_s;
        regRd && regAddr == REG_ENABLE;
    endsequence

    sequence levelRead_s;
        regRd && regAddr == REG_LEVEL;
    endsequence

    sequence clearRead_s;
        regRd && regAddr == REG_CLEAR;
    endsequence

    sequence quietEvents_s;
        !underrunEvt && !overflowEvt;
    endsequence

    // a written enable value lands at the strobe edge, only its low bits kept
    enable_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        enableWrite_s |=> intEnable_ff == $past(regWrData[FLAG_W-1:0]))
        else $error("enable write did not land");

    // nothing but an enable write may move the enable bits
    enable_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        !(regWr && regAddr == REG_ENABLE) |=> $stable(intEnable_ff))
        else $error("enable bits changed without a write");

    // a clear write with no event pending drops exactly the written bits
    clear_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        clearWrite_s ##0 quietEvents_s
        |=> statusFlags_ff == ($past(statusFlags_ff) & ~$past(regWrData[FLAG_W-1:0])))
        else $error("clear write touched the wrong flags");

    // flags only move on an event, a status read or a clear write
    flags_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
        quietEvents_s ##0 (!(regRd && regAddr == REG_STATUS) && !(regWr && regAddr == REG_CLEAR))
        |=> $stable(statusFlags_ff))
        else $error("flags moved with nothing to move them");

    // underrun flag rises only after an underrun event
    underrun_cause_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
        $rose(statusFlags_ff[BIT_UNDERRUN]) |-> $past(underrunEvt))
        else $error("underrun flag rose without an event");

    // slip flag rises only after one of the two slips
    slip_cause_a: assert property (@(posedge clock) disable iff (!arst_n) // R3
        $rose(statusFlags_ff[BIT_SLIP]) |-> $past(underrunEvt || overflowEvt))
        else $error("slip flag rose without an event");

    // overflow flag rises only after an overflow event
    overflow_cause_a: assert property (@(posedge clock) disable iff (!arst_n) // R6
        $rose(statusFlags_ff[BIT_OVERFLOW]) |-> $past(overflowEvt))
        else $error("overflow flag rose without an event");

    // the two slip kinds exclude each other, so the cause bits are never ambiguous
    slip_kind_a: assert property (@(posedge clock) disable iff (!arst_n)
        underrunEvt |-> !overflowEvt)
        else $error("underrun and overflow in one cycle");

    // read data stand one cycle only; the bus sees zero otherwise
    idle_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        !regRd |=> regRdData == '0)
        else $error("read data outside a read cycle");

    enable_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        enableRead_s |=> regRdData == DATA_W'($past(intEnable_ff)))
        else $error("enable read returned wrong value");

    level_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        levelRead_s |=> regRdData == DATA_W'($past(fillLevel)))
        else $error("level read returned wrong value");

    // the clear register is write-only and must not echo anything
    clear_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        clearRead_s |=> regRdData == '0)
        else $error("clear register read back nonzero");

    // bits above the three flags are reserved and read zero
    status_upper_a: assert property (@(posedge clock) disable iff (!arst_n)
        statusRead_s |=> regRdData[DATA_W-1:FLAG_W] == '0)
        else $error("reserved status bits read nonzero");

    // no underrun without a read at fill zero
    no_false_under_a: assert property (@(posedge clock) disable iff (!arst_n) // R2
        !(sysRd && fillLevel == '0) |=> !underrunEvt)
        else $error("underrun without an empty read");

    // no overflow without a write at full
    no_false_over_a: assert property (@(posedge clock) disable iff (!arst_n) // R4
        !(lineWr && fillLevel == FULL_CNT) |=> !overflowEvt)
        else $error("overflow without a full write");

    // outside slips the level moves by one per strobe
    level_step_a: assert property (@(posedge clock) disable iff (!arst_n)
        !(sysRd && fillLevel == '0) && !(lineWr && fillLevel == FULL_CNT)
        |=> fillLevel == $past(fillLevel) + CNT_W'($past(lineWr)) - CNT_W'($past(sysRd)))
        else $error("fill level stepped wrongly");

    // the level can never pass two frames
    level_bound_a: assert property (@(posedge clock) disable iff (!arst_n)
        fillLevel <= FULL_CNT)
        else $error("fill level beyond depth");

    sys_valid_a: assert property (@(posedge clock) disable iff (!arst_n)
        sysRd |=> sysValid)
        else $error("read byte not marked valid");

    sys_idle_a: assert property (@(posedge clock) disable iff (!arst_n)
        !sysRd |=> !sysValid && $stable(sysData))
        else $error("system side moved without a read");

    // with every source masked the line stays low unless an enable write lands
    irq_masked_a: assert property (@(posedge clock) disable iff (!arst_n)
        intEnable_ff == '0 && !(regWr && regAddr == REG_ENABLE) |=> !irq)
        else $error("interrupt raised while masked");
endmodule : rsb_status_flags

//--- rsb_status_flags_tb_top.sv
`timescale 1ns/100ps

module rsb_status_flags_tb_top
    import rsb_pkg::*;
;
    logic              clock;
    logic              arst_n;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic              regWr;
    logic              regRd;
    logic [DATA_W-1:0] regRdData;
    logic [7:0]        lineData;
    logic              lineWr;
    logic              sysRd;
    logic [7:0]        sysData;
    logic              sysValid;
    logic              irq;
    logic [DATA_W-1:0] rd;
    int                mismatches;
    int                nChecks;

    rsb_status_flags u_dut (
        .clock(clock), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .lineData(lineData),
        .lineWr(lineWr), .sysRd(sysRd), .sysData(sysData), .sysValid(sysValid), .irq(irq)
    );

    // 25 mhz framer clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // every task starts just after an edge and ends just after one
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a; regWrData <= d; regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
        #1;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe, so sample there
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask : reg_rd

    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            lineWr <= 1'b1; lineData <= 8'(i);
            @(posedge clock);
        end
        lineWr <= 1'b0;
        #1;
    endtask : push

    task automatic pull(input int n);
        repeat (n) begin
            sysRd <= 1'b1;
            @(posedge clock);
        end
        sysRd <= 1'b0;
        #1;
    endtask : pull

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        reg_rd(a, rd);
        check(rd, exp);
    endtask : expect_reg

    task automatic t_underrun;
        pull(1);
        settle(2);
        expect_reg(REG_LEVEL, 8'h1f);
        expect_reg(REG_STATUS, 8'h03);
        expect_reg(REG_STATUS, 8'h00);
    endtask : t_underrun

    // an event landing on the status read must survive it
    task automatic t_coincide;
        pull(31);
        expect_reg(REG_LEVEL, 8'h00);
        sysRd <= 1'b1;
        @(posedge clock);
        sysRd <= 1'b0; regAddr <= REG_STATUS; regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 check(regRdData, 8'h00);
        settle(1);
        expect_reg(REG_STATUS, 8'h03);
    endtask : t_coincide

    task automatic t_overflow;
        push(33);
        settle(2);
        expect_reg(REG_LEVEL, 8'h40);
        expect_reg(REG_STATUS, 8'h00);
        push(1);
        settle(2);
        expect_reg(REG_LEVEL, 8'h21);
        expect_reg(REG_STATUS, 8'h05);
        expect_reg(REG_STATUS, 8'h00);
    endtask : t_overflow

    // raise, mask, unmask and clear the level interrupt
    task automatic t_irq;
        reg_wr(REG_ENABLE, 8'h04);
        push(32);
        settle(2);
        check(irq, 8'h01);
        reg_wr(REG_ENABLE, 8'h02);
        settle(1);
        check(irq, 8'h00);
        reg_wr(REG_ENABLE, 8'h04);
        settle(1);
        check(irq, 8'h01);
        reg_wr(REG_CLEAR, 8'h07);
        settle(1);
        check(irq, 8'h00);
        expect_reg(REG_STATUS, 8'h00);
    endtask : t_irq

    task automatic t_map;
        reg_wr(8'h10, 8'hff);
        expect_reg(8'h10, 8'h00);
        expect_reg(REG_CLEAR, 8'h00);
        reg_wr(REG_ENABLE, 8'hff);
        expect_reg(REG_ENABLE, 8'h07);
        reg_wr(REG_ENABLE, 8'h00);
    endtask : t_map

    // fifo order, valid strobe and replay of the last frame on an empty read
    task automatic t_data;
        pull(33);
        expect_reg(REG_LEVEL, 8'h00);
        push(32);
        pull(1);
        check(sysValid, 8'h01);
        check(sysData, 8'h00);
        settle(1);
        check(sysValid, 8'h00);
        pull(31);
        check(sysData, 8'h1f);
        pull(1);
        check(sysData, 8'h00);
        settle(1);
        expect_reg(REG_STATUS, 8'h03);
    endtask : t_data

    task automatic final_report;
        if (mismatches == 0 && nChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #200000;
        mismatches++;
        final_report();
    end

    initial begin
        arst_n = 1'b0; regAddr = 8'h00; regWrData = 8'h00; regWr = 1'b0;
        regRd = 1'b0; lineData = 8'h00; lineWr = 1'b0; sysRd = 1'b0;
        mismatches = 0; nChecks = 0;
        settle(10);
        arst_n <= 1'b1;
        settle(1);
        check(irq, 8'h00);
        expect_reg(REG_STATUS, 8'h00);
        expect_reg(REG_ENABLE, 8'h00);
        expect_reg(REG_LEVEL, 8'h00);
        t_underrun();
        t_coincide();
        t_overflow();
        t_irq();
        t_map();
        t_data();
        final_report();
    end
endmodule : rsb_status_flags_tb_top
